// *** skt_defs.svh ***
`ifndef SKT_DEFS_SVH
`define SKT_DEFS_SVH

// ----------------------------------------
// Reset values, fixed page number and byte lane positions
// ----------------------------------------
`define SKT_ACC_RST       8'h00
`define SKT_TABLE_HIGH_LATCH_RST      8'h00
`define SKT_LAST_PAGE     8'hff
`define SKT_LOW_BYTE_LSB  0
`define SKT_HIGH_BYTE_LSB 8

`endif

// *** skt_exec.sv ***
`timescale 1ns/1ns
`include "skt_defs.svh"

// Functional notes
// - Swap to accumulator: acc low nibble gets byte high nibble; byte, flags unchanged.
// - Byte zero test: zero byte discards prefetch, adds dummy cycle; else one cycle.
// - Copy then test: byte goes to accumulator; zero value skips with dummy cycle.
// - Bit zero test: selected bit zero discards prefetch, adds dummy cycle.
// - Current page table read: low byte to memory, high byte to latch.
// - Last page table read: low byte to memory, high byte to latch.
// - Register exclusive-or: result to accumulator, only zero flag changes.
// - Memory exclusive-or: result back to the byte, only zero flag changes.
// - Immediate exclusive-or: acc xor constant to accumulator, only zero flag changes.
module skt_exec
	import skt_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        instr_valid,
	input  wire skt_instr_t  instr,
	output logic             instr_ready,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic [7:0]  pc_page,
	input  wire logic [7:0]  table_pointer,
	input  wire logic [15:0] rom_rdata,
	output logic             rom_rd,
	output logic [15:0]      rom_addr,
	output skt_mem_wr_t      mem_wr,
	output logic [7:0]       acc,
	output logic             zero_flag,
	output logic [7:0]       table_high_latch,
	output logic             discard_prefetch
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	skt_state_t st;
	skt_state_t next_st;
	logic       taken;
	logic [7:0] xor_mem;
	logic [7:0] xor_imm;

	assign instr_ready = (st.fsm == SKT_ST_RUN);
	assign taken       = instr_valid && instr_ready;
	assign xor_mem     = st.acc ^ mem_rdata;
	assign xor_imm     = st.acc ^ instr.imm;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st         = st;
		next_st.wr.en   = 1'b0;
		next_st.discard = 1'b0;
		next_st.rom_rd  = 1'b0;
		case (st.fsm)
			SKT_ST_RUN:
			begin
				if (instr_valid)
				begin
					case (instr.op)
						SKT_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR:
						begin
							next_st.acc = {mem_rdata[3:0], mem_rdata[7:4]};
						end
						SKT_OP_SKIP_WHEN_ZERO:
						begin
							if (is_zero(mem_rdata))
							begin
								next_st.discard = 1'b1;
								next_st.fsm     = SKT_ST_DUMMY;
							end
						end
						SKT_OP_COPY_THEN_SKIP_WHEN_ZERO:
						begin
							next_st.acc = mem_rdata;
							if (is_zero(mem_rdata))
							begin
								next_st.discard = 1'b1;
								next_st.fsm     = SKT_ST_DUMMY;
							end
						end
						SKT_OP_SKIP_WHEN_BIT_ZERO:
						begin
							if (!mem_rdata[instr.bit_sel])
							begin
								next_st.discard = 1'b1;
								next_st.fsm     = SKT_ST_DUMMY;
							end
						end
						SKT_OP_TABLE_READ_CURRENT_PAGE:
						begin
							next_st.rom_rd    = 1'b1;
							next_st.rom_addr  = {pc_page, table_pointer};
							next_st.pend_addr = instr.addr;
							next_st.fsm       = SKT_ST_TABLE;
						end
						SKT_OP_TABLE_READ_LAST_PAGE:
						begin
							next_st.rom_rd    = 1'b1;
							next_st.rom_addr  = {`SKT_LAST_PAGE, table_pointer};
							next_st.pend_addr = instr.addr;
							next_st.fsm       = SKT_ST_TABLE;
						end
						SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR:
						begin
							next_st.acc  = xor_mem;
							next_st.zero = is_zero(xor_mem);
						end
						SKT_OP_EXCLUSIVE_OR_INTO_MEMORY:
						begin
							next_st.wr.en   = 1'b1;
							next_st.wr.addr = instr.addr;
							next_st.wr.data = xor_mem;
							next_st.zero    = is_zero(xor_mem);
						end
						SKT_OP_EXCLUSIVE_OR_IMMEDIATE:
						begin
							next_st.acc  = xor_imm;
							next_st.zero = is_zero(xor_imm);
						end
						default:
						begin
							next_st.fsm = SKT_ST_RUN;
						end
					endcase
				end
			end
			SKT_ST_DUMMY:
			begin
				// Stands in for the discarded successor so fetch can refill
				next_st.fsm = SKT_ST_RUN;
			end
			SKT_ST_TABLE:
			begin
				// ROM answers during the cycle its address is held
				next_st.wr.en            = 1'b1;
				next_st.wr.addr          = st.pend_addr;
				next_st.wr.data          = rom_rdata[`SKT_LOW_BYTE_LSB +: 8];
				next_st.table_high_latch = rom_rdata[`SKT_HIGH_BYTE_LSB +: 8];
				next_st.fsm              = SKT_ST_RUN;
			end
			default:
			begin
				next_st.fsm = SKT_ST_RUN;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st                  <= '0;
			st.fsm              <= SKT_ST_RUN;
			st.acc              <= `SKT_ACC_RST;
			st.table_high_latch <= `SKT_TABLE_HIGH_LATCH_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign rom_rd           = st.rom_rd;
	assign rom_addr         = st.rom_addr;
	assign mem_wr           = st.wr;
	assign acc              = st.acc;
	assign zero_flag        = st.zero;
	assign table_high_latch = st.table_high_latch;
	assign discard_prefetch = st.discard;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence dummy_slot;
		discard_prefetch && !instr_ready ##1 instr_ready && !discard_prefetch;
	endsequence

	sequence table_fill(logic [7:0] page);
		rom_rd && rom_addr == {page, $past(table_pointer)}
		##1 mem_wr.en && mem_wr.data == $past(rom_rdata[7:0])
			&& table_high_latch == $past(rom_rdata[15:8]) && zero_flag == $past(zero_flag, 2);
	endsequence

	skt_op_t taken_op;

	// Idle cycles read as a no-op, so each check keys only on an accepted instruction
	assign taken_op = taken ? instr.op : SKT_OP_NONE;

	AST_SWAP: assert property (taken_op == SKT_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR |=>
		acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(zero_flag) && !mem_wr.en)
		else $error("swap result wrong");
	AST_SZ_SKIP: assert property (taken_op == SKT_OP_SKIP_WHEN_ZERO && mem_rdata == 8'h00
		|=> dummy_slot) else $error("zero byte did not skip");
	AST_SZ_RUN: assert property (taken_op == SKT_OP_SKIP_WHEN_ZERO && mem_rdata != 8'h00
		|=> instr_ready && !discard_prefetch && $stable(zero_flag)) else $error("nonzero byte skipped");
	AST_SZA: assert property (taken_op == SKT_OP_COPY_THEN_SKIP_WHEN_ZERO |=>
		acc == $past(mem_rdata) && discard_prefetch == ($past(mem_rdata) == 8'h00))
		else $error("copy then skip wrong");
	AST_BIT: assert property (taken_op == SKT_OP_SKIP_WHEN_BIT_ZERO |=>
		discard_prefetch == !$past(mem_rdata[instr.bit_sel])) else $error("bit test wrong");
	AST_BIT_KEEP: assert property (taken_op == SKT_OP_SKIP_WHEN_BIT_ZERO |=>
		$stable(zero_flag) && $stable(acc) && !mem_wr.en) else $error("bit test changed state");
	AST_TRD_CUR: assert property (taken_op == SKT_OP_TABLE_READ_CURRENT_PAGE |=>
		table_fill($past(pc_page))) else $error("current page table read wrong");
	AST_TRD_LAST: assert property (taken_op == SKT_OP_TABLE_READ_LAST_PAGE |=>
		table_fill(`SKT_LAST_PAGE)) else $error("last page table read wrong");
	AST_XOR_ACC: assert property (taken_op == SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR |=>
		acc == $past(st.acc ^ mem_rdata) && !mem_wr.en) else $error("xor to acc wrong");
	AST_EXCLUSIVE_OR_INTO_MEMORY: assert property (taken_op == SKT_OP_EXCLUSIVE_OR_INTO_MEMORY |=>
		mem_wr.en && mem_wr.data == $past(st.acc ^ mem_rdata) && $stable(acc))
		else $error("xor to memory wrong");
	AST_EXCLUSIVE_OR_INTO_MEMORY_ZERO: assert property (taken_op == SKT_OP_EXCLUSIVE_OR_INTO_MEMORY |=>
		zero_flag == (mem_wr.data == 8'h00)) else $error("xor to memory zero flag wrong");
	AST_XORI: assert property (taken_op == SKT_OP_EXCLUSIVE_OR_IMMEDIATE |=>
		acc == $past(st.acc ^ instr.imm)) else $error("xor immediate wrong");
	AST_ZERO: assert property ((taken_op == SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR
		|| taken_op == SKT_OP_EXCLUSIVE_OR_IMMEDIATE) |=> zero_flag == (acc == 8'h00))
		else $error("zero flag wrong");

endmodule // skt_exec

// *** skt_mem_model.sv ***
`timescale 1ns/1ns
module skt_mem_model
	import skt_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [7:0]  rd_addr,
	input  wire skt_mem_wr_t mem_wr,
	input  wire logic        rom_rd,
	input  wire logic [15:0] rom_addr,
	output logic      [7:0]  mem_rdata,
	output logic      [15:0] rom_rdata
);
	logic [7:0]  ram [256];
	logic [15:0] last_word;
	initial
	begin
		for (int i = 0; i < 256; i++)
			ram[i] = i[7:0];
		last_word = 16'h0000;
	end
	// ----------------------------------------
	// Stale word is inverted so a late sample cannot pass
	// ----------------------------------------
	assign rom_rdata = rom_rd ? (rom_addr ^ 16'h5a3c) : ~last_word;
	assign mem_rdata = ram[rd_addr];
	always @(posedge sys_clk)
	begin
		if (rom_rd)
			last_word <= rom_addr ^ 16'h5a3c;
		if (mem_wr.en)
			ram[mem_wr.addr] <= mem_wr.data;
	end
endmodule // skt_mem_model

// *** skt_pkg.sv ***
package skt_pkg;

	typedef enum logic [3:0] {
		SKT_OP_NONE                           = 4'h0,
		SKT_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 4'h1,
		SKT_OP_SKIP_WHEN_ZERO                 = 4'h2,
		SKT_OP_COPY_THEN_SKIP_WHEN_ZERO       = 4'h3,
		SKT_OP_SKIP_WHEN_BIT_ZERO             = 4'h4,
		SKT_OP_TABLE_READ_CURRENT_PAGE        = 4'h5,
		SKT_OP_TABLE_READ_LAST_PAGE           = 4'h6,
		SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR  = 4'h7,
		SKT_OP_EXCLUSIVE_OR_INTO_MEMORY       = 4'h8,
		SKT_OP_EXCLUSIVE_OR_IMMEDIATE         = 4'h9
	} skt_op_t;

	typedef enum logic [2:0] {
		SKT_ST_RUN   = 3'b001,
		SKT_ST_DUMMY = 3'b010,
		SKT_ST_TABLE = 3'b100
	} skt_fsm_t;

	typedef struct packed {
		skt_op_t    op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] imm;
	} skt_instr_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} skt_mem_wr_t;

	typedef struct packed {
		skt_fsm_t    fsm;
		logic [7:0]  acc;
		logic        zero;
		logic [7:0]  table_high_latch;
		skt_mem_wr_t wr;
		logic        discard;
		logic        rom_rd;
		logic [15:0] rom_addr;
		logic [7:0]  pend_addr;
	} skt_state_t;

endpackage

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
	import skt_pkg::*;
	logic        sys_clk, sys_rst, instr_valid, instr_ready, rom_rd, zero_flag, discard_prefetch;
	skt_instr_t  instr;
	logic [7:0]  mem_rdata, pc_page, table_pointer, acc, table_high_latch;
	logic [15:0] rom_rdata, rom_addr;
	skt_mem_wr_t mem_wr;
	int          fails, cmp_count;

	skt_exec DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .mem_rdata(mem_rdata), .pc_page(pc_page),
		.table_pointer(table_pointer), .rom_rdata(rom_rdata), .rom_rd(rom_rd),
		.rom_addr(rom_addr), .mem_wr(mem_wr), .acc(acc), .zero_flag(zero_flag),
		.table_high_latch(table_high_latch), .discard_prefetch(discard_prefetch));
	skt_mem_model mem_model (.sys_clk(sys_clk), .rd_addr(instr.addr), .mem_wr(mem_wr),
		.rom_rd(rom_rd), .rom_addr(rom_addr), .mem_rdata(mem_rdata), .rom_rdata(rom_rdata));

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ----------------------------------------
	// Issue at a falling edge, return one cycle later
	// ----------------------------------------
	task automatic exec(skt_op_t op, logic [7:0] a, logic [2:0] b, logic [7:0] imm);
		int n;
		n = 0;
		// Spacer edge: instr_valid is never lowered and raised in one time step
		@(negedge sys_clk);
		while (instr_ready !== 1'b1)
		begin
			@(negedge sys_clk);
			n++;
			if (n > 8)
			begin
				fails++;
				conclude();
			end
		end
		instr = '{op, a, b, imm};
		instr_valid = 1'b1;
		@(negedge sys_clk);
		instr_valid = 1'b0;
	endtask

	task automatic skip_chk(logic e);
		chk("discard", {15'h0, e}, {15'h0, discard_prefetch});
		chk("ready", {15'h0, ~e}, {15'h0, instr_ready});
	endtask

	task automatic t_xor();
		exec(SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR, 8'h3c, 3'h0, 8'h00);
		chk("acc", 16'h003c, 16'(acc));
		chk("zero", 16'h0000, 16'(zero_flag));
		exec(SKT_OP_EXCLUSIVE_OR_IMMEDIATE, 8'h00, 3'h0, 8'h3c);
		chk("acc", 16'h0000, 16'(acc));
		chk("zero", 16'h0001, 16'(zero_flag));
	endtask

	task automatic t_swap();
		exec(SKT_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'h5a, 3'h0, 8'h00);
		chk("acc", 16'h00a5, 16'(acc));
		chk("zero", 16'h0001, 16'(zero_flag));
		chk("wr_en", 16'h0000, 16'(mem_wr.en));
		exec(SKT_OP_NONE, 8'h00, 3'h0, 8'h00);
		chk("acc", 16'h00a5, 16'(acc));
		chk("zero", 16'h0001, 16'(zero_flag));
		chk("wr_en", 16'h0000, 16'(mem_wr.en));
	endtask

	task automatic t_skip();
		exec(SKT_OP_SKIP_WHEN_ZERO, 8'h00, 3'h0, 8'h00);
		skip_chk(1'b1);
		exec(SKT_OP_SKIP_WHEN_ZERO, 8'h01, 3'h0, 8'h00);
		skip_chk(1'b0);
		exec(SKT_OP_COPY_THEN_SKIP_WHEN_ZERO, 8'h00, 3'h0, 8'h00);
		skip_chk(1'b1);
		exec(SKT_OP_COPY_THEN_SKIP_WHEN_ZERO, 8'h07, 3'h0, 8'h00);
		skip_chk(1'b0);
		chk("acc", 16'h0007, 16'(acc));
		exec(SKT_OP_SKIP_WHEN_BIT_ZERO, 8'h04, 3'h2, 8'h00);
		skip_chk(1'b0);
		exec(SKT_OP_SKIP_WHEN_BIT_ZERO, 8'h04, 3'h3, 8'h00);
		skip_chk(1'b1);
	endtask

	// Word the ROM model returns is address xor 5a3c
	task automatic t_table(skt_op_t op, logic [15:0] wa);
		table_pointer = wa[7:0];
		exec(op, 8'h90, 3'h0, 8'h00);
		chk("rom_rd", 16'h0001, 16'(rom_rd));
		chk("rom_addr", wa, rom_addr);
		@(negedge sys_clk);
		chk("wr_en", 16'h0001, 16'(mem_wr.en));
		chk("wr_addr", 16'h0090, 16'(mem_wr.addr));
		chk("wr_data", {8'h00, wa[7:0] ^ 8'h3c}, 16'(mem_wr.data));
		chk("latch", {8'h00, wa[15:8] ^ 8'h5a}, 16'(table_high_latch));
		// Read the byte back to prove the low byte really landed in memory
		exec(SKT_OP_COPY_THEN_SKIP_WHEN_ZERO, 8'h90, 3'h0, 8'h00);
		chk("readback", {8'h00, wa[7:0] ^ 8'h3c}, 16'(acc));
	endtask

	task automatic t_reset();
		sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("rst_acc", 16'h0000, 16'(acc));
		chk("rst_zero", 16'h0000, 16'(zero_flag));
		chk("rst_latch", 16'h0000, 16'(table_high_latch));
		chk("rst_ready", 16'h0001, 16'(instr_ready));
		sys_rst = 1'b0;
	endtask

	task automatic t_exclusive_or_into_memory();
		exec(SKT_OP_COPY_THEN_SKIP_WHEN_ZERO, 8'h07, 3'h0, 8'h00);
		chk("acc", 16'h0007, 16'(acc));
		chk("zero", 16'h0000, 16'(zero_flag));
		exec(SKT_OP_EXCLUSIVE_OR_INTO_ACCUMULATOR, 8'h87, 3'h0, 8'h00);
		chk("acc", 16'h0080, 16'(acc));
		chk("zero", 16'h0000, 16'(zero_flag));
		exec(SKT_OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h80, 3'h0, 8'h00);
		chk("wr_data", 16'h0000, 16'(mem_wr.data));
		chk("wr_addr", 16'h8080, {mem_wr.en, 7'h00, mem_wr.addr});
		chk("acc", 16'h0080, 16'(acc));
		chk("zero", 16'h0001, 16'(zero_flag));
		// The cleared byte must now make a byte-zero test skip
		exec(SKT_OP_SKIP_WHEN_ZERO, 8'h80, 3'h0, 8'h00);
		skip_chk(1'b1);
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	initial
	begin
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		pc_page = 8'h12;
		table_pointer = 8'h00;
		fails = 0;
		cmp_count = 0;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_xor();
		t_swap();
		t_skip();
		t_table(SKT_OP_TABLE_READ_CURRENT_PAGE, 16'h1234);
		t_table(SKT_OP_TABLE_READ_LAST_PAGE, 16'hff56);
		t_reset();
		t_exclusive_or_into_memory();
		conclude();
	end
endmodule // testbench
